/* File: pkg/dmarb_pkg.sv */
// Operation
// R1: Arbitrate data memory, extended space included, among core, DMA and debug unit.
// R2: Coincident requests grant only the highest current priority requester.
// R3: Losers are stalled, not dropped, and served after the winner completes.
// R4: Default scheme puts core at level zero and DMA at level three.
// R5: Debug unit always sits at level four, the lowest.
// R6: Levels one and two stay empty except core at one when DMA raised.
// R7: Value 0x0000 gives core, DMA, debug; 0x0020 gives DMA, core, debug.
// R8: Software writes only the two defined encodings; others are reserved.
// R9: Masters raised above the core keep their relative order.
// R10: Masters below the core keep their relative order in every scheme.
// R11: Priority value may change any time and applies to later arbitrations.
// R12: At most one grant per cycle; stalled requesters hold their request.
`default_nettype none
package dmarb_pkg;
    localparam int          DMARB_NUM_MASTERS   = 3;
    localparam int          DMARB_CORE          = 0;
    localparam int          DMARB_DMA           = 1;
    localparam int          DMARB_DEBUG         = 2;
    localparam logic [2:0]  DMARB_LEVEL_ZERO    = 3'h0;
    localparam logic [2:0]  DMARB_LEVEL_ONE     = 3'h1;
    localparam logic [2:0]  DMARB_LEVEL_THREE   = 3'h3;
    localparam logic [2:0]  DMARB_LEVEL_FOUR    = 3'h4;
    localparam logic [15:0] DMARB_PRIO_DEFAULT  = 16'h0000;
    localparam logic [15:0] DMARB_PRIO_DMA_HIGH = 16'h0020;
    localparam logic [15:0] DMARB_PRIO_RESET    = 16'h0000;
    localparam logic [3:0]  DMARB_OFS_PRIO_CTRL = 4'h0;
    localparam logic [3:0]  DMARB_OFS_STATUS    = 4'h4;
    localparam int          DMARB_STAT_OWNER_LSB = 0;
    localparam int          DMARB_STAT_BUSY_BIT  = 3;
    localparam int          DMARB_STAT_PEND_LSB  = 4;
    localparam logic [1:0]  DMARB_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  DMARB_RESP_SLVERR   = 2'h2;
endpackage
`default_nettype wire

/* File: src/dmarb_pick.sv */
`default_nettype none
module dmarb_pick
    import dmarb_pkg::*;
(
    input  wire logic [2:0]  req_in,
    input  wire logic        dma_high_in,
    output logic      [2:0]  pick_out
);
    // Levels of each master under the current scheme
    logic [2:0] lvl_core;
    logic [2:0] lvl_dma;
    logic [2:0] lvl_dbg;
    always_comb begin
        lvl_core = dma_high_in ? DMARB_LEVEL_ONE : DMARB_LEVEL_ZERO;    // [R4] [R6] [R7]
        lvl_dma  = dma_high_in ? DMARB_LEVEL_ZERO : DMARB_LEVEL_THREE;  // [R4] [R7] [R9]
        lvl_dbg  = DMARB_LEVEL_FOUR;                                    // [R5] [R10]
        pick_out = 3'h0;
        // Lowest level number wins; one-hot result
        if (req_in[DMARB_CORE] && (!req_in[DMARB_DMA] || lvl_core < lvl_dma)) begin // [R2]
            pick_out[DMARB_CORE] = 1'b1;
        end else if (req_in[DMARB_DMA]) begin
            pick_out[DMARB_DMA] = 1'b1;
        end else if (req_in[DMARB_DEBUG] && lvl_dbg == DMARB_LEVEL_FOUR) begin
            pick_out[DMARB_DEBUG] = 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: src/dmarb_top.sv */
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
module dmarb_top
    import dmarb_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        clk_en_in,
    // Requesters: core, DMA, debug; done ends the granted access
    input  wire logic [2:0]  req_in,
    input  wire logic [2:0]  done_in,
    output logic      [2:0]  grant_out,
    // AXI4-Lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        DMARB_ST_IDLE = 2'b01,
        DMARB_ST_BUSY = 2'b10
    } dmarb_state_t;

    typedef struct packed {
        dmarb_state_t state;
        logic [2:0]   grant;
        logic [15:0]  prio;
        logic         aw_got;
        logic [3:0]   aw_addr;
        logic         w_got;
        logic [31:0]  w_data;
        logic [3:0]   w_strb;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
    } dmarb_regs_t;

    dmarb_regs_t r_q;
    dmarb_regs_t r_d;
    logic [2:0]  pick;
    logic        dma_high;

    function automatic logic [15:0] dmarb_merge16(input logic [15:0] old_v,
                                                  input logic [31:0] new_v,
                                                  input logic [3:0]  strb);
        logic [15:0] res;
        res = old_v;
        if (strb[0]) begin
            res[7:0] = new_v[7:0];
        end
        if (strb[1]) begin
            res[15:8] = new_v[15:8];
        end
        return res;
    endfunction

    // Any value other than the raised encoding behaves as the default scheme
    assign dma_high = (r_q.prio == DMARB_PRIO_DMA_HIGH); // [R7] [R8] [R11]

    dmarb_pick u_pick (
        .req_in      (req_in),
        .dma_high_in (dma_high),
        .pick_out    (pick)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        r_d = r_q;
        // Arbitration
        case (r_q.state)
            DMARB_ST_IDLE: begin
                if (pick != 3'h0) begin // [R1] [R2] [R12]
                    r_d.grant = pick;
                    r_d.state = DMARB_ST_BUSY;
                end
            end
            DMARB_ST_BUSY: begin
                // Owner keeps the bus until its access completes
                if ((done_in & r_q.grant) != 3'h0) begin // [R3]
                    r_d.grant = 3'h0;
                    r_d.state = DMARB_ST_IDLE;
                end
            end
            default: begin
                r_d.grant = 3'h0;
                r_d.state = DMARB_ST_IDLE;
            end
        endcase
        // Register bus write
        if (s_axi_awvalid && s_axi_awready) begin
            r_d.aw_got  = 1'b1;
            r_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            r_d.w_got  = 1'b1;
            r_d.w_data = s_axi_wdata;
            r_d.w_strb = s_axi_wstrb;
        end
        if (r_q.aw_got && r_q.w_got && !r_q.bvalid) begin
            r_d.aw_got = 1'b0;
            r_d.w_got  = 1'b0;
            r_d.bvalid = 1'b1;
            if (r_q.aw_addr == DMARB_OFS_PRIO_CTRL) begin
                r_d.prio  = dmarb_merge16(r_q.prio, r_q.w_data, r_q.w_strb); // [R11]
                r_d.bresp = DMARB_RESP_OKAY;
            end else if (r_q.aw_addr == DMARB_OFS_STATUS) begin
                r_d.bresp = DMARB_RESP_OKAY;
            end else begin
                r_d.bresp = DMARB_RESP_SLVERR;
            end
        end
        if (r_q.bvalid && s_axi_bready) begin
            r_d.bvalid = 1'b0;
        end
        // Register bus read
        if (s_axi_arvalid && s_axi_arready) begin
            r_d.rvalid = 1'b1;
            r_d.rdata  = 32'h0000_0000;
            r_d.rresp  = DMARB_RESP_OKAY;
            if (s_axi_araddr == DMARB_OFS_PRIO_CTRL) begin
                r_d.rdata[15:0] = r_q.prio;
            end else if (s_axi_araddr == DMARB_OFS_STATUS) begin
                r_d.rdata[DMARB_STAT_OWNER_LSB +: 3] = r_q.grant;
                r_d.rdata[DMARB_STAT_BUSY_BIT]       = (r_q.state == DMARB_ST_BUSY);
                r_d.rdata[DMARB_STAT_PEND_LSB +: 3]  = req_in & ~r_q.grant;
            end else begin
                r_d.rresp = DMARB_RESP_SLVERR;
            end
        end else if (r_q.rvalid && s_axi_rready) begin
            r_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            r_q        <= '0;
            r_q.state  <= DMARB_ST_IDLE;
            r_q.prio   <= DMARB_PRIO_RESET; // [R4]
        end else if (clk_en_in) begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign grant_out     = r_q.grant;
    assign s_axi_awready = !r_q.aw_got;
    assign s_axi_wready  = !r_q.w_got;
    assign s_axi_bvalid  = r_q.bvalid;
    assign s_axi_bresp   = r_q.bresp;
    assign s_axi_arready = !r_q.rvalid;
    assign s_axi_rvalid  = r_q.rvalid;
    assign s_axi_rdata   = r_q.rdata;
    assign s_axi_rresp   = r_q.rresp;

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    one_grant_a: assert property ($onehot0(grant_out)) // [R12]
        else $error("More than one grant");
    grant_req_a: assert property (clk_en_in && r_q.state == DMARB_ST_IDLE && req_in != 3'h0
        |=> grant_out != 3'h0) // [R1]
        else $error("Request not granted from idle");
    core_first_a: assert property (clk_en_in && r_q.state == DMARB_ST_IDLE && req_in[0]
        && !dma_high |=> grant_out == 3'b001) // [R2]
        else $error("Core not first in default scheme");
    dma_first_a: assert property (clk_en_in && r_q.state == DMARB_ST_IDLE && req_in[1]
        && dma_high |=> grant_out == 3'b010) // [R7]
        else $error("DMA not first in raised scheme");
    dma_over_dbg_a: assert property (clk_en_in && r_q.state == DMARB_ST_IDLE
        && req_in == 3'b110 |=> grant_out == 3'b010) // [R10]
        else $error("Debug beat DMA");
    debug_last_a: assert property (grant_out == 3'b100 |-> $past(req_in[1:0]) == 2'b00
        || $past(r_q.state) == DMARB_ST_BUSY) // [R5]
        else $error("Debug granted over a higher master");
    hold_grant_a: assert property (grant_out != 3'h0 && (done_in & grant_out) == 3'h0
        |=> $stable(grant_out)) // [R3]
        else $error("Grant changed before done");
    reset_prio_a: assert property ($rose(reset_n_in) |-> r_q.prio == DMARB_PRIO_RESET) // [R4]
        else $error("Priority not default after reset");
    prio_write_a: assert property (clk_en_in && r_q.aw_got && r_q.w_got && !r_q.bvalid
        && r_q.aw_addr == DMARB_OFS_PRIO_CTRL && r_q.w_strb == 4'hF
        |=> r_q.prio == $past(r_q.w_data[15:0])) // [R11]
        else $error("Priority write lost");

    contend_c: cover property (req_in == 3'b111 ##1 grant_out != 3'h0);
    raised_c: cover property (dma_high && grant_out == 3'b010);
    debug_c: cover property (grant_out == 3'b100);
    write_c: cover property (s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

/* File: verif/dmarb_req_model.sv */
`default_nettype none
module dmarb_req_model (
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic [2:0] start_in,
    input  wire logic [3:0] hold_in,
    input  wire logic [2:0] grant_in,
    output logic      [2:0] req_out,
    output logic      [2:0] done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    ////////////////////////////////////////
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            req_out  <= 3'h0;
            done_out <= 3'h0;
            cnt_q    <= 4'h0;
        end else begin
            done_out <= 3'h0;
            req_out  <= req_out | start_in;
            if ((grant_in & ~done_out) != 3'h0) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q >= hold_in) begin
                    // Request drops only with completion
                    req_out  <= (req_out | start_in) & ~grant_in;
                    done_out <= grant_in;
                    cnt_q    <= 4'h0;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
`default_nettype none
module testbench;
    import dmarb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, awv, awr, wv, wr, bv, br, arv, ar_rdy, rv, rr, cen;
    logic [3:0]  awa, ara, strb, hold;
    logic [31:0] wd, rd;
    logic [1:0]  bresp, rresp;
    logic [2:0]  req, done, grant, start, prev;
    logic [2:0]  got[$];
    int          error_cnt = 0;
    int          n_tests = 0;
    logic [15:0] prio_tab [5] = '{16'h0000, 16'h0020, 16'h0020, 16'h0000, 16'h0000};
    logic [2:0]  start_tab [5] = '{3'h7, 3'h7, 3'h5, 3'h6, 3'h7};
    logic [8:0]  exp_tab [5] = '{9'h111, 9'h10A, 9'h021, 9'h022, 9'h111};
    int          n_tab [5] = '{3, 3, 2, 2, 3};
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    dmarb_top uut (.sys_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(cen), .req_in(req),
        .done_in(done), .grant_out(grant), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ar_rdy), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
    dmarb_req_model far (.clk_in(clk), .reset_n_in(rst_n), .start_in(start), .hold_in(hold),
        .grant_in(grant), .req_out(req), .done_out(done));
    ////////////////////////////////////////
    task automatic check(input logic [31:0] g, input logic [31:0] e, input string msg);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, g, e);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] e);
        logic [1:0] r;
        int         t;
        r = 2'bxx;
        t = 0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        strb <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (t < 100) begin
            @(posedge clk);
            t++;
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (bv) begin
                br <= 1'b0;
                r = bresp;
                t = 1000;
            end
        end
        check(32'(r), 32'(e), "write response");
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] e);
        logic [33:0] r;
        int          t;
        r = 'x;
        t = 0;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        while (t < 100) begin
            @(posedge clk);
            t++;
            if (arv && ar_rdy) arv <= 1'b0;
            if (rv) begin
                rr <= 1'b0;
                r = {rresp, rd};
                t = 1000;
            end
        end
        check(r[31:0], ed, "read data");
        check(32'(r[33:32]), 32'(e), "read response");
    endtask
    task automatic arb(input logic [2:0] s, input logic [8:0] e, input int n);
        int t;
        t = 0;
        @(posedge clk);
        got.delete();
        start <= s;
        @(posedge clk);
        start <= 3'h0;
        while ((got.size() < n || grant != 3'h0) && t < 300) begin
            @(posedge clk);
            t++;
        end
        for (int i = 0; i < n; i++) check(32'(got[i]), 32'(e[3*i +: 3]), "grant order");
    endtask
    ////////////////////////////////////////
    always @(posedge clk) begin
        prev <= grant;
        if (rst_n && grant != 3'h0 && prev == 3'h0) begin
            got.push_back(grant);
            check(32'($onehot(grant & req)), 32'h1, "grant not one-hot");
        end
    end
    initial begin
        repeat (6000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        {awv, wv, br, arv, rr, start, hold, awa, ara, wd, strb, prev} = '0;
        cen = 1'b1;
        rst_n = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        axi_rd(DMARB_OFS_PRIO_CTRL, 32'h0, DMARB_RESP_OKAY);
        axi_rd(DMARB_OFS_STATUS, 32'h0, DMARB_RESP_OKAY);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            hold <= 4'(i * 2);
            axi_wr(DMARB_OFS_PRIO_CTRL, 32'(prio_tab[i]), 4'hF, DMARB_RESP_OKAY);
            axi_rd(DMARB_OFS_PRIO_CTRL, 32'(prio_tab[i]), DMARB_RESP_OKAY);
            arb(start_tab[i], exp_tab[i], n_tab[i]);
            $display("test scheme %0d done", i);
        end
        // Debug unit owns while the scheme flips; waiters follow the new order
        hold <= 4'hA;
        start <= 3'h4;
        @(posedge clk);
        start <= 3'h0;
        axi_wr(DMARB_OFS_PRIO_CTRL, 32'h20, 4'h3, DMARB_RESP_OKAY);
        axi_rd(DMARB_OFS_STATUS, 32'hC, DMARB_RESP_OKAY);
        arb(3'h3, 9'h00A, 2);
        $display("test live change done");
        axi_wr(DMARB_OFS_PRIO_CTRL, 32'h0, 4'hC, DMARB_RESP_OKAY);
        axi_wr(4'h8, 32'h0, 4'hF, DMARB_RESP_SLVERR);
        axi_wr(DMARB_OFS_STATUS, 32'h0, 4'hF, DMARB_RESP_OKAY);
        axi_rd(DMARB_OFS_PRIO_CTRL, 32'h20, DMARB_RESP_OKAY);
        axi_rd(4'hC, 32'h0, DMARB_RESP_SLVERR);
        $display("test access done");
        // Frozen arbiter must not grant until enable returns
        cen <= 1'b0;
        start <= 3'h1;
        @(posedge clk);
        start <= 3'h0;
        repeat (4) @(posedge clk);
        check(32'(grant), 32'h0, "grant while frozen");
        cen <= 1'b1;
        arb(3'h0, 9'h001, 1);
        $display("test enable done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
